// [hw/sst_device.sv]
/*
  Device end of the switch supervision timers: watchdog, auto-retry timer,
  input low-time detector, PWM oscillator with calibration, external clock
  monitor and thermal prewarning.
  Assumes pins arrive through sst_link_if and die temperature as a code.
*/
`timescale 1ns/1ps
module sst_device #(
  parameter int unsigned WDTO_CYC   = sst_pkg::WDTO_CYC,
  parameter int unsigned IN_LOW_CYC = sst_pkg::IN_LOW_CYC,
  parameter int unsigned PWM_CYC    = sst_pkg::PWM_DEF_CYC,
  parameter int unsigned RETRY_DIV  = 1,
  parameter logic [7:0]  OT_THRESH  = 8'h7D
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  sst_link_if.dev         link,
  input  wire logic       watchdog_disable,
  input  wire logic       retry_en,
  input  wire logic [1:0] retry_period,
  input  wire logic [7:0] die_temp,
  input  wire logic       ext_clk_sel,
  input  wire logic [6:0] duty_pct,
  input  wire logic       fast_pwm,
  output logic            pwm_out,
  output logic            retry_pulse,
  output logic [1:0]      delatch,
  output logic            cal_ok,
  output logic            open_load_off_diag,
  output logic            open_load_on_diag,
  output logic            output_short_diag,
  output logic            protect_on
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic rst_s, rst_rise, frm_rise, cs_s, cs_rise, cs_fall, ec_rise;
  logic [1:0] in_s;

  sst_sync u_rst (.mclk(mclk), .reset(reset), .din(link.reset_pin_n),
                  .dout(rst_s), .rise(rst_rise), .fall());
  sst_sync u_frm (.mclk(mclk), .reset(reset), .din(link.frame_valid),
                  .dout(), .rise(frm_rise), .fall());
  sst_sync u_cs  (.mclk(mclk), .reset(reset), .din(link.chip_select_n),
                  .dout(cs_s), .rise(cs_rise), .fall(cs_fall));
  sst_sync u_ec  (.mclk(mclk), .reset(reset), .din(link.ext_clk),
                  .dout(), .rise(ec_rise), .fall());

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      sst_sync u_in (.mclk(mclk), .reset(reset), .din(link.chan_in[g]),
                     .dout(in_s[g]), .rise(), .fall());
    end
  endgenerate

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  logic [31:0] wd_q;
  logic        fs_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wd_q <= 32'h0;
      fs_q <= 1'b0;
    end else if (!rst_s || rst_rise || watchdog_disable || frm_rise) begin
      // Timeout counts from the reset pin release, or last frame
      wd_q <= 32'h0;
      fs_q <= (rst_s && !rst_rise && !watchdog_disable) ? fs_q & ~frm_rise : 1'b0;
    end else if (wd_q >= WDTO_CYC - 1) begin
      fs_q <= 1'b1;
    end else begin
      wd_q <= wd_q + 32'h1;
    end
  end
  assign link.fail_safe = fs_q;

  // ------------------------------------------------------------
  // Auto-retry period
  // ------------------------------------------------------------
  function automatic logic [31:0] retry_cyc(input logic [1:0] sel);
    unique case (sel)
      2'b00: retry_cyc = 32'(sst_pkg::RETRY_00_CYC / RETRY_DIV);
      2'b01: retry_cyc = 32'(sst_pkg::RETRY_01_CYC / RETRY_DIV);
      2'b10: retry_cyc = 32'(sst_pkg::RETRY_10_CYC / RETRY_DIV);
      2'b11: retry_cyc = 32'(sst_pkg::RETRY_11_CYC / RETRY_DIV);
    endcase
  endfunction

  logic [31:0] rt_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rt_q        <= 32'h0;
      retry_pulse <= 1'b0;
    end else if (!retry_en) begin
      rt_q        <= 32'h0;
      retry_pulse <= 1'b0;
    end else if (rt_q >= retry_cyc(retry_period) - 32'h1) begin
      rt_q        <= 32'h0;
      retry_pulse <= 1'b1;
    end else begin
      rt_q        <= rt_q + 32'h1;
      retry_pulse <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Direct input low-time detect, one per channel
  // ------------------------------------------------------------
  // Host must hold the input low the full time; shorter lows are ignored
  generate
    for (g = 0; g < 2; g++) begin : g_low
      logic [31:0] lo_q;
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          lo_q       <= 32'h0;
          delatch[g] <= 1'b0;
        end else if (in_s[g]) begin
          lo_q       <= 32'h0;
          delatch[g] <= 1'b0;
        end else if (lo_q == IN_LOW_CYC - 1) begin
          lo_q       <= lo_q + 32'h1;
          delatch[g] <= 1'b1;
        end else begin
          delatch[g] <= 1'b0;
          if (lo_q < IN_LOW_CYC) lo_q <= lo_q + 32'h1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Calibration pulse on chip select
  // ------------------------------------------------------------
  logic [31:0] cs_q;
  logic [31:0] per_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cs_q <= 32'h0;
    end else if (cs_fall) begin
      cs_q <= 32'h0;
    end else if (!cs_s && cs_q <= sst_pkg::CAL_MAX_CYC) begin
      cs_q <= cs_q + 32'h1;
    end
  end

  // Pulse width sets the PWM period: each low-time cycle adds PWM_CYC / CAL_MAX_CYC period cycles
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      per_q  <= 32'(PWM_CYC);
      cal_ok <= 1'b0;
    end else if (cs_rise && cs_q >= sst_pkg::CAL_MIN_CYC
                 && cs_q <= sst_pkg::CAL_MAX_CYC) begin
      per_q  <= cs_q * 32'(PWM_CYC / sst_pkg::CAL_MAX_CYC);
      cal_ok <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // PWM generator, internal or external clock
  // ------------------------------------------------------------
  logic [31:0] pw_q;
  logic        tick;
  assign tick = ext_clk_sel ? ec_rise : 1'b1;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pw_q    <= 32'h0;
      pwm_out <= 1'b0;
    end else if (tick) begin
      pw_q    <= (pw_q >= per_q - 32'h1) ? 32'h0 : pw_q + 32'h1;
      pwm_out <= (pw_q * 32'd100) < (per_q * {25'h0, duty_pct});
    end
  end

  // ------------------------------------------------------------
  // External clock monitor
  // ------------------------------------------------------------
  logic [31:0] ep_q;
  logic        ef_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ep_q <= 32'h0;
      ef_q <= 1'b0;
    end else if (!ext_clk_sel) begin
      // Preset, so the first edge after selection is not a short period
      ep_q <= 32'(sst_pkg::EXT_MIN_PER);
      ef_q <= 1'b0;
    end else if (ec_rise) begin
      ep_q <= 32'h0;
      ef_q <= (ep_q < sst_pkg::EXT_MIN_PER);
    end else if (ep_q > sst_pkg::EXT_MAX_PER) begin
      ef_q <= 1'b1;
    end else begin
      ep_q <= ep_q + 32'h1;
    end
  end
  assign link.ext_fault = ef_q;

  // ------------------------------------------------------------
  // Thermal prewarning and diagnostic availability
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link.ot_warn       <= 1'b0;
      open_load_off_diag <= 1'b0;
      open_load_on_diag  <= 1'b0;
      output_short_diag  <= 1'b0;
    end else begin
      link.ot_warn       <= die_temp >= OT_THRESH;
      // Limits hold for 1 kHz high slew (fast_pwm); slower PWM keeps every diagnostic available
      open_load_off_diag <= !fast_pwm || duty_pct <= 7'd62;
      open_load_on_diag  <= !fast_pwm || duty_pct >= 7'd35;
      output_short_diag  <= !fast_pwm || duty_pct <= 7'd90;
    end
  end
  assign protect_on = 1'b1; // Protection never gated by duty
endmodule

// [hw/sst_pkg.sv]
/*
  Package for the switch supervision timers: timing constants, register
  offsets and field positions shared by both ends.
  Assumes a 200 MHz system clock on both ends.
*/
package sst_pkg;

  // ------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;

  // ------------------------------------------------------------
  // Times in their own units
  // ------------------------------------------------------------
  localparam int unsigned WDTO_MS       = 310;
  localparam int unsigned IN_LOW_MS     = 250;
  localparam int unsigned RETRY_00_US   = 150_000;
  localparam int unsigned RETRY_01_US   = 75_000;
  localparam int unsigned RETRY_10_US   = 37_500;
  localparam int unsigned RETRY_11_US   = 17_700;
  localparam int unsigned PWM_DEF_HZ    = 400;
  localparam int unsigned CAL_MIN_NS    = 1_500;
  localparam int unsigned CAL_MAX_US    = 100;
  localparam int unsigned EXT_MAX_KHZ   = 730;
  localparam int unsigned EXT_MIN_KHZ   = 7;
  localparam int unsigned CAL_TOL_PCT   = 10;

  // ------------------------------------------------------------
  // Derived cycle counts
  // ------------------------------------------------------------
  localparam int unsigned WDTO_CYC      = WDTO_MS * (CLK_HZ / 1000);
  localparam int unsigned IN_LOW_CYC    = IN_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_00_CYC  = RETRY_00_US * CLK_PER_US;
  localparam int unsigned RETRY_01_CYC  = RETRY_01_US * CLK_PER_US;
  localparam int unsigned RETRY_10_CYC  = RETRY_10_US * CLK_PER_US;
  localparam int unsigned RETRY_11_CYC  = RETRY_11_US * CLK_PER_US;
  localparam int unsigned PWM_DEF_CYC   = CLK_HZ / PWM_DEF_HZ;
  localparam int unsigned CAL_MIN_CYC   = (CAL_MIN_NS * CLK_PER_US + 999) / 1000;
  localparam int unsigned CAL_MAX_CYC   = CAL_MAX_US * CLK_PER_US;
  // Edge-to-edge period bounds of the external clock
  localparam int unsigned EXT_MIN_PER   = CLK_HZ / (EXT_MAX_KHZ * 1000);
  localparam int unsigned EXT_MAX_PER   = CLK_HZ / (EXT_MIN_KHZ * 1000);

  // ------------------------------------------------------------
  // Host-side registers (word offsets are byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT   = 4'h8;
  localparam logic [3:0] REG_IRQ_CLR    = 4'hC;
  localparam logic [3:0] REG_IRQ_EN     = 4'h0; // Upper window, full address in A_IRQ_EN
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0] A_CTRL         = 5'h00;
  localparam logic [4:0] A_STATUS       = 5'h04;
  localparam logic [4:0] A_IRQ_STAT     = 5'h08;
  localparam logic [4:0] A_IRQ_CLR      = 5'h0C;
  localparam logic [4:0] A_IRQ_EN       = 5'h10;

  // CTRL fields
  localparam int unsigned C_FRAME       = 0;  // Write 1: send a serial frame
  localparam int unsigned C_WATCHDOG_DISABLE      = 1;
  localparam int unsigned C_RETRY_EN    = 2;
  localparam int unsigned C_RETRY_LO    = 3;  // Two bits
  localparam int unsigned C_CAL         = 5;  // Write 1: send calibration pulse
  localparam int unsigned C_IN_HOLD     = 6;  // Two bits, hold input low
  localparam int unsigned C_RST_PIN     = 8;
  localparam int unsigned C_EXT_EN      = 9;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // STATUS / IRQ fields
  localparam int unsigned S_FAILSAFE    = 0;
  localparam int unsigned S_EXT_FAULT   = 1;
  localparam int unsigned S_OT_WARN     = 2;
  localparam int unsigned S_DELATCH     = 3;
  localparam int unsigned S_CAL_DONE    = 4;
  localparam int unsigned S_RETRY       = 5;
  localparam int unsigned NUM_EV        = 6;

endpackage

// [hw/sst_link_if.sv]
/*
  Pins between the supervised device and its host.
  Assumes both ends run from their own 200 MHz clocks.
*/
`timescale 1ns/1ps
interface sst_link_if;
  logic       reset_pin_n;
  logic       chip_select_n;
  logic       frame_valid;
  logic [1:0] chan_in;
  logic       ext_clk;
  logic       fail_safe;
  logic       ext_fault;
  logic       ot_warn;

  modport dev (
    input  reset_pin_n, chip_select_n, frame_valid, chan_in, ext_clk,
    output fail_safe, ext_fault, ot_warn
  );
  modport host (
    output reset_pin_n, chip_select_n, frame_valid, chan_in, ext_clk,
    input  fail_safe, ext_fault, ot_warn
  );
endinterface

// [hw/sst_sync.sv]
/*
  Two-flop synchroniser with rising/falling edge detect on the second flop.
  Assumes an input from outside the clock domain.
*/
`timescale 1ns/1ps
module sst_sync (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout,
  output logic      rise,
  output logic      fall
);
  logic s1_q, s2_q, s3_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule

// [hw/sst_host.sv]
/*
  Host end: Avalon-MM slave registers that drive the link pins and
  collect device status with sticky interrupt bits.
  Assumes sst_link_if to the device and a 200 MHz clock.
*/
`timescale 1ns/1ps
module sst_host (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  sst_link_if.host                        link,
  input  wire logic [sst_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output logic [31:0]                     readdata,
  output logic                            waitrequest,
  output logic                            irq
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic fs_s, ef_s, ot_s;
  sst_sync u_fs (.mclk(mclk), .reset(reset), .din(link.fail_safe),
                 .dout(fs_s), .rise(), .fall());
  sst_sync u_ef (.mclk(mclk), .reset(reset), .din(link.ext_fault),
                 .dout(ef_s), .rise(), .fall());
  sst_sync u_ot (.mclk(mclk), .reset(reset), .din(link.ot_warn),
                 .dout(ot_s), .rise(), .fall());

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [sst_pkg::NUM_EV-1:0] stat_q, en_q, ev;
  logic [7:0]  frm_q;
  // Wide enough for the whole calibration low time
  logic [15:0] cal_q;
  logic        ack_q;
  logic        wr, rd;

  // Write lands at the edge where waitrequest is low; read data is ready then
  assign wr = write & ack_q;
  assign rd = read & ~ack_q;
  assign waitrequest = (read | write) & ~ack_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) ack_q <= 1'b0;
    else       ack_q <= (read | write) & ~ack_q;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= sst_pkg::CTRL_RESET;
      en_q   <= '0;
    end else if (wr && address == sst_pkg::A_CTRL) begin
      ctrl_q <= writedata;
    end else if (wr && address == sst_pkg::A_IRQ_EN) begin
      en_q <= writedata[sst_pkg::NUM_EV-1:0];
    end
  end

  // Frame strobe width and calibration low pulse from counters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      frm_q <= 8'h0;
      cal_q <= 16'h0;
    end else begin
      if (wr && address == sst_pkg::A_CTRL && writedata[sst_pkg::C_FRAME])
        frm_q <= 8'h08;
      else if (frm_q != 8'h0)
        frm_q <= frm_q - 8'h1;
      // About 1.5 us low, inside the accepted window
      if (wr && address == sst_pkg::A_CTRL && writedata[sst_pkg::C_CAL])
        cal_q <= 16'(sst_pkg::CAL_MIN_CYC + 8);
      else if (cal_q != 16'h0)
        cal_q <= cal_q - 16'h1;
    end
  end

  // Divided external clock, 200 MHz / 400 = 500 kHz, inside range
  logic [7:0] dv_q;
  logic       ec_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dv_q <= 8'h0;
      ec_q <= 1'b0;
    end else if (dv_q == 8'd199) begin
      dv_q <= 8'h0;
      ec_q <= ~ec_q & ctrl_q[sst_pkg::C_EXT_EN];
    end else begin
      dv_q <= dv_q + 8'h1;
    end
  end

  assign link.reset_pin_n   = ctrl_q[sst_pkg::C_RST_PIN];
  assign link.chip_select_n = (cal_q == 16'h0);
  assign link.frame_valid   = (frm_q != 8'h0);
  assign link.chan_in       = ~ctrl_q[sst_pkg::C_IN_HOLD +: 2];
  assign link.ext_clk       = ec_q;

  // ------------------------------------------------------------
  // Sticky events, set wins over clear
  // ------------------------------------------------------------
  assign ev = {3'b000, ot_s, ef_s, fs_s};
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) stat_q <= '0;
    else if (wr && address == sst_pkg::A_IRQ_CLR)
      stat_q <= (stat_q & ~writedata[sst_pkg::NUM_EV-1:0]) | ev;
    else
      stat_q <= stat_q | ev;
  end
  assign irq = |(stat_q & en_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) readdata <= 32'h0;
    else if (rd) begin
      unique case (address)
        sst_pkg::A_CTRL:     readdata <= ctrl_q;
        sst_pkg::A_STATUS:   readdata <= {29'h0, ot_s, ef_s, fs_s};
        sst_pkg::A_IRQ_STAT: readdata <= {26'h0, stat_q};
        sst_pkg::A_IRQ_EN:   readdata <= {26'h0, en_q};
        default:             readdata <= 32'h0;
      endcase
    end
  end
endmodule

// [sim/sst_chk.sv]
/* Assertions on the link between host and device ends.
   Assumes link signals and device side inputs in the mclk domain. */
`timescale 1ns/1ps
module sst_chk #(
  parameter int unsigned WDTO_CYC = 400,
  parameter int unsigned EXT_MAX  = 28571,
  parameter logic [7:0]  OT_TH    = 8'h7D
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       reset_pin_n,
  input wire logic       frame_valid,
  input wire logic       ext_clk,
  input wire logic       fail_safe,
  input wire logic       ext_fault,
  input wire logic       ot_warn,
  input wire logic       watchdog_disable,
  input wire logic       ext_clk_sel,
  input wire logic [7:0] die_temp
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Idle and clock-gap counters
  // ----------------------------------------
  logic [31:0] idle_q;
  logic [31:0] gap_q;
  logic        ext_q;
  logic        fv_q;
  // Saturating, so long idle runs never wrap
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      idle_q <= '0;
    // Idle runs from the frame's rising edge, where the device restarts
    end else if ((frame_valid && !fv_q) || !reset_pin_n || watchdog_disable) begin
      idle_q <= '0;
    end else if (idle_q < WDTO_CYC + 8) begin
      idle_q <= idle_q + 32'h1;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_q <= 1'b0;
      fv_q  <= 1'b0;
    end else begin
      ext_q <= ext_clk;
      fv_q  <= frame_valid;
    end
  end
  // Cleared while unselected: a gated monitor is not blamed
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_q <= '0;
    end else if ((ext_clk && !ext_q) || !ext_clk_sel) begin
      gap_q <= '0;
    end else if (gap_q < EXT_MAX + 16) begin
      gap_q <= gap_q + 32'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_trip_early: assert property ($rose(fail_safe) |-> idle_q >= WDTO_CYC)
    else $error("fail-safe before timeout");
  a_trip_late: assert property (idle_q == WDTO_CYC + 8 |-> fail_safe)
    else $error("fail-safe missing after timeout");
  a_frame_clear: assert property ($rose(frame_valid) |-> ##[1:6] !fail_safe)
    else $error("frame did not clear fail-safe");
  a_wd_off: assert property (watchdog_disable [*6] |-> !fail_safe)
    else $error("fail-safe while watchdog disabled");
  a_pin_low: assert property (!reset_pin_n [*6] |-> !fail_safe)
    else $error("fail-safe while reset pin low");
  a_clk_lost: assert property (gap_q == EXT_MAX + 16 |-> ext_fault)
    else $error("missing clock not flagged");
  a_ot_high: assert property ((die_temp >= OT_TH) [*6] |-> ot_warn)
    else $error("prewarning missing");
  a_ot_low: assert property ((die_temp < OT_TH) [*6] |-> !ot_warn)
    else $error("prewarning below threshold");
  cover property ($rose(fail_safe));
  cover property ($rose(ext_fault));
  cover property ($rose(ot_warn));
endmodule

// [sim/switch_supervision_timers_tb.sv]
/* Bench: host and device ends joined by the link, driven over Avalon-MM.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
module switch_supervision_timers_tb;
  // Short counts keep the run brief
  localparam int unsigned WDTO  = 400;
  localparam int unsigned INLOW = 300;
  localparam int unsigned PWMC  = 20000;
  localparam int unsigned RDIV  = 20000;
  logic        mclk;
  logic        reset;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        watchdog_disable;
  logic        retry_en;
  logic [1:0]  retry_period;
  logic [7:0]  die_temp;
  logic        ext_clk_sel;
  logic [6:0]  duty_pct;
  logic        fast_pwm;
  logic        pwm_out;
  logic        retry_pulse;
  logic [1:0]  delatch;
  logic        cal_ok;
  logic        open_load_off_diag;
  logic        open_load_on_diag;
  logic        output_short_diag;
  logic        protect_on;
  int          n_errors;
  int          n_checks;
  sst_link_if sst_link_if_inst ();
  sst_host sst_host_inst (
    .mclk, .reset, .link(sst_link_if_inst), .address, .read, .write, .writedata,
    .readdata, .waitrequest, .irq
  );
  sst_device #(.WDTO_CYC(WDTO), .IN_LOW_CYC(INLOW), .PWM_CYC(PWMC), .RETRY_DIV(RDIV),
    .OT_THRESH(8'h7D)) sst_device_inst (
    .mclk, .reset, .link(sst_link_if_inst), .watchdog_disable, .retry_en, .retry_period,
    .die_temp, .ext_clk_sel, .duty_pct, .fast_pwm, .pwm_out, .retry_pulse, .delatch,
    .cal_ok, .open_load_off_diag, .open_load_on_diag, .output_short_diag, .protect_on
  );
  sst_chk #(.WDTO_CYC(WDTO), .EXT_MAX(sst_pkg::EXT_MAX_PER), .OT_TH(8'h7D)) sst_chk_inst (
    .mclk, .reset, .watchdog_disable, .ext_clk_sel, .die_temp,
    .reset_pin_n(sst_link_if_inst.reset_pin_n), .frame_valid(sst_link_if_inst.frame_valid),
    .ext_clk(sst_link_if_inst.ext_clk), .fail_safe(sst_link_if_inst.fail_safe),
    .ext_fault(sst_link_if_inst.ext_fault), .ot_warn(sst_link_if_inst.ot_warn)
  );
  always #2.5 mclk = ~mclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    bit ok;
    ok = 1'b0;
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge mclk);
      ok = (waitrequest === 1'b0);
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
    if (!ok) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Cycles between two rises of pwm_out or retry_pulse; -1 if none
  task automatic period(input bit sel, output int p);
    int  t0;
    logic s;
    logic pv;
    t0 = -1;
    p  = -1;
    pv = 1'b1;
    for (int i = 0; i < 45000 && p < 0; i++) begin
      @(posedge mclk);
      s = sel ? retry_pulse : pwm_out;
      if (s === 1'b1 && pv !== 1'b1) begin
        if (t0 >= 0) p = i - t0;
        else t0 = i;
      end
      pv = s;
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int p;
    int lo;
    int n;
    int rc [4];
    logic [6:0] dt [6];
    logic [2:0] de [6];
    rc = '{sst_pkg::RETRY_00_CYC, sst_pkg::RETRY_01_CYC, sst_pkg::RETRY_10_CYC,
           sst_pkg::RETRY_11_CYC};
    dt = '{7'h3E, 7'h3F, 7'h23, 7'h22, 7'h5A, 7'h5B};
    de = '{3'h7, 3'h3, 3'h7, 3'h5, 3'h3, 3'h2};
    mclk = 1'b0;
    reset = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    watchdog_disable = 1'b0;
    retry_en = 1'b0;
    retry_period = 2'h0;
    die_temp = 8'h19;
    ext_clk_sel = 1'b0;
    duty_pct = 7'h32;
    fast_pwm = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdc(sst_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdc(sst_pkg::A_IRQ_EN, 32'hFFFF_FFFF, 32'h0);
    wr(5'h14, 32'hFFFF_FFFF);
    rdc(5'h14, 32'hFFFF_FFFF, 32'h0);
    rdc(sst_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h0);
    wr(sst_pkg::A_IRQ_EN, 32'h7);
    wr(sst_pkg::A_CTRL, 32'h100);
    repeat (4) begin
      repeat (WDTO - 100) @(posedge mclk);
      wr(sst_pkg::A_CTRL, 32'h101);
    end
    rdc(sst_pkg::A_STATUS, 32'h1, 32'h0);
    repeat (WDTO + 20) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    wr(sst_pkg::A_CTRL, 32'h101);
    repeat (10) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h1, 32'h0);
    wr(sst_pkg::A_IRQ_CLR, 32'h1);
    rdc(sst_pkg::A_IRQ_STAT, 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
    watchdog_disable <= 1'b1;
    wr(sst_pkg::A_CTRL, 32'h0);
    wr(sst_pkg::A_CTRL, 32'h100);
    repeat (2 * WDTO) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h1, 32'h0);
    die_temp <= 8'h7D;
    repeat (8) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h4, 32'h4);
    chk(32'(irq), 32'h1);
    wr(sst_pkg::A_IRQ_EN, 32'h3);
    chk(32'(irq), 32'h0);
    die_temp <= 8'h7C;
    repeat (8) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h4, 32'h0);
    wr(sst_pkg::A_IRQ_CLR, 32'h4);
    rdc(sst_pkg::A_IRQ_STAT, 32'h4, 32'h0);
    ext_clk_sel <= 1'b1;
    wr(sst_pkg::A_CTRL, 32'h300);
    repeat (3000) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h2, 32'h0);
    wr(sst_pkg::A_CTRL, 32'h100);
    repeat (sst_pkg::EXT_MAX_PER + 100) @(posedge mclk);
    rdc(sst_pkg::A_STATUS, 32'h2, 32'h2);
    chk(32'(irq), 32'h1);
    ext_clk_sel <= 1'b0;
    wr(sst_pkg::A_CTRL, 32'h140);
    n = 0;
    while (delatch[0] !== 1'b1 && n < 2 * INLOW) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= INLOW - 2 && n <= INLOW + 10), 32'h1);
    wr(sst_pkg::A_CTRL, 32'h100);
    period(1'b0, p);
    chk(32'(p * 520 >= PWMC * 400 && p * 280 <= PWMC * 400), 32'h1);
    wr(sst_pkg::A_CTRL, 32'h120);
    n = 0;
    lo = 0;
    // Low time counted on the wire, not trusted from the host
    while (cal_ok !== 1'b1 && n < 40000) begin
      @(posedge mclk);
      n++;
      if (sst_link_if_inst.chip_select_n === 1'b0) lo++;
    end
    chk(32'(cal_ok), 32'h1);
    chk(32'(lo + 2 >= sst_pkg::CAL_MIN_CYC && lo <= sst_pkg::CAL_MAX_CYC), 32'h1);
    n = lo * PWMC / 20000;
    period(1'b0, p);
    period(1'b0, p);
    chk(32'(p * 10 >= n * 9 && p * 10 <= n * 11), 32'h1);
    retry_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      retry_period <= 2'(k);
      period(1'b1, p);
      period(1'b1, p);
      lo = rc[k] / RDIV;
      chk(32'(p * 10 >= lo * 7 && p * 10 <= lo * 13), 32'h1);
    end
    fast_pwm <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      duty_pct <= dt[k];
      repeat (4) @(posedge mclk);
      chk(32'({open_load_off_diag, open_load_on_diag, output_short_diag}), 32'(de[k]));
    end
    chk(32'(protect_on), 32'h1);
    fast_pwm <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(32'({open_load_off_diag, open_load_on_diag, output_short_diag}), 32'h7);
    tally_and_finish();
  end
endmodule
